// >>> rtl/mpl_core.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - 10M: first received nibble reaches RXD within 7 bit times of line.
// - 10M: first line bit leaves within 2 bit times of TXD sampled.
// - 100M: first /J/ bit leaves within 3 bit times of TXEN sampled; the code takes 4 to 5 REF_CLK cycles, 10 to 12.5 bit times.
// - 100M half duplex: CRS rises 0 to 4 bit times after TXEN; the code raises it 4 to 5 REF_CLK cycles later, 10 to 12.5 bit times.
// - Half duplex: CRS falls 0 to 4 bit times after TXEN drops; at 100M the code takes 4 to 5 REF_CLK cycles, 10 to 12.5 bit times.
// - 10M half duplex: CRS rises within 2 bit times of TXEN.
// - 100M: /J/ nibble on RXD within 17 bit times of line arrival.
// - 100M: CRS rises 10 to 14 bit times after incoming /J/.
// - 100M half duplex: COL rises 9 to 13 bits after /J/ while sending.
// - 100M: CRS falls 13 to 18 bit times after incoming /T/.
// - 100M half duplex: COL falls 13 to 18 bit times after /T/.
// - Power-on reset completes between 40 and 500 ms.
// - 10M bit time is 100 ns.
module mpl_core
    import mpl_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    input  wire logic       SPEED_100,
    input  wire logic       FULL_DUPLEX,
    input  wire logic       TX_CLK_IN,
    input  wire logic       TXEN,
    input  wire logic [3:0] TXD,
    input  wire logic       LINE_RECEIVE_ACTIVE,
    input  wire logic [3:0] LINE_RECEIVE_NIBBLE,
    input  wire logic       LINE_RECEIVE_END,
    output logic            LINE_TRANSMIT_ACTIVE,
    output logic [3:0]      LINE_TRANSMIT_NIBBLE,
    output logic            RXDV,
    output logic [3:0]      RXD,
    output logic            CRS,
    output logic            COL,
    output logic            RESET_DONE
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic [2:0] txc_s_q, txc_s_d;
    logic [2:0] ten_s_q, ten_s_d;
    logic [2:0] rxa_s_q, rxa_s_d;
    logic [2:0] rxe_s_q, rxe_s_d;
    logic       txc_f_q, txc_f_d;
    logic       ten_f_q, ten_f_d;
    logic       rxa_f_q, rxa_f_d;
    logic       rxe_f_q, rxe_f_d;
    // Transmit data runs one stage deeper than the clock sync: the MAC
    // launches the next nibble on the very edge we detect, so the nibble
    // that edge samples is the one seen the cycle before it arrived
    logic [15:0] txd_q, txd_d;
    logic [3:0] rxn_q, rxn_d;
    logic       txc_rise;
    logic [3:0] txd_taken;

    // Shift in and filter
    always_comb begin
        txc_s_d = {txc_s_q[1:0], TX_CLK_IN};
        ten_s_d = {ten_s_q[1:0], TXEN};
        rxa_s_d = {rxa_s_q[1:0], LINE_RECEIVE_ACTIVE};
        rxe_s_d = {rxe_s_q[1:0], LINE_RECEIVE_END};
        txc_f_d = (txc_s_q[1] == txc_s_q[2]) ? txc_s_q[2] : txc_f_q;
        ten_f_d = (ten_s_q[1] == ten_s_q[2]) ? ten_s_q[2] : ten_f_q;
        rxa_f_d = (rxa_s_q[1] == rxa_s_q[2]) ? rxa_s_q[2] : rxa_f_q;
        rxe_f_d = (rxe_s_q[1] == rxe_s_q[2]) ? rxe_s_q[2] : rxe_f_q;
        txd_d   = {txd_q[11:0], TXD};
        rxn_d   = LINE_RECEIVE_NIBBLE;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            txc_s_q <= 3'h0;
            ten_s_q <= 3'h0;
            rxa_s_q <= 3'h0;
            rxe_s_q <= 3'h0;
            txc_f_q <= 1'b0;
            ten_f_q <= 1'b0;
            rxa_f_q <= 1'b0;
            rxe_f_q <= 1'b0;
            txd_q   <= 16'h0;
            rxn_q   <= 4'h0;
        end else begin
            txc_s_q <= txc_s_d;
            ten_s_q <= ten_s_d;
            rxa_s_q <= rxa_s_d;
            rxe_s_q <= rxe_s_d;
            txc_f_q <= txc_f_d;
            ten_f_q <= ten_f_d;
            rxa_f_q <= rxa_f_d;
            rxe_f_q <= rxe_f_d;
            txd_q   <= txd_d;
            rxn_q   <= rxn_d;
        end
    end

    // Filtered rise of the nibble clock
    assign txc_rise  = txc_f_d & ~txc_f_q;

    // Oldest data stage: the value that stood before the clock edge
    assign txd_taken = txd_q[15:12];

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset counter
    logic [31:0] por_q, por_d;
    logic        done_q, done_d;

    // minimum wait
    // The upper limit needs no logic: the count ends far below it
    always_comb begin
        por_d  = por_q;
        done_d = done_q;
        if (!done_q) begin
            if (por_q >= POR_CYCLES - 1) begin
                done_d = 1'b1;
            end else begin
                por_d = por_q + 32'h1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            por_q  <= 32'h0;
            done_q <= 1'b0;
        end else begin
            por_q  <= por_d;
            done_q <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay counters for carrier and data edges
    // bit-time scaling
    // Counts come from the package, already scaled from bit times to cycles
    logic [DLY_W-1:0] txd_cnt_q, txd_cnt_d;
    logic [DLY_W-1:0] rxd_cnt_q, rxd_cnt_d;
    logic [DLY_W-1:0] crs_cnt_q, crs_cnt_d;
    logic [DLY_W-1:0] col_cnt_q, col_cnt_d;
    logic             ltx_q, ltx_d;
    logic [3:0]       ltn_q, ltn_d;
    logic             rxdv_q, rxdv_d;
    logic [3:0]       rxd_q, rxd_d;
    logic             crs_tx_q, crs_tx_d;
    logic             crs_rx_q, crs_rx_d;
    logic             col_q, col_d;
    logic             rx_on;
    logic             ten_sampled;
    logic             half;

    assign rx_on       = rxa_f_q & ~rxe_f_q;
    assign ten_sampled = txc_rise & ten_f_q;
    assign half        = ~FULL_DUPLEX;

    // Count down by one; holds at zero so an idle counter never wraps
    function automatic logic [DLY_W-1:0] cnt_dec(input logic [DLY_W-1:0] v);
        return (v == '0) ? v : v - DLY_W'(1);
    endfunction : cnt_dec

    // Transmit path and transmit-side carrier
    always_comb begin
        txd_cnt_d = txd_cnt_q;
        ltx_d     = ltx_q;
        ltn_d     = ltn_q;
        crs_tx_d  = crs_tx_q;
        crs_cnt_d = crs_cnt_q;
        if (!done_q) begin
            // Nothing leaves for the line until power-up is over
            ltx_d    = 1'b0;
            crs_tx_d = 1'b0;
        end else if (ten_sampled && !ltx_q && txd_cnt_q == '0) begin
            txd_cnt_d = SPEED_100 ? DLY_W'(1) : DLY_W'(TX10_CYC);
        end else if (txd_cnt_q != '0) begin
            txd_cnt_d = cnt_dec(txd_cnt_q);
            if (txd_cnt_q == DLY_W'(1)) begin
                ltx_d = 1'b1;
            end
        end else if (!ten_f_q) begin
            // Line goes idle with the filtered enable, no extra tail
            ltx_d = 1'b0;
        end

        // Nibble taken at the same clock edge that samples the enable
        if (ten_sampled) begin
            ltn_d = txd_taken;
        end
        if (done_q && half && ten_f_q) begin
            crs_tx_d  = 1'b1;
            crs_cnt_d = SPEED_100 ? DLY_W'(1) : DLY_W'(OFF10_CYC);
        end else if (crs_cnt_q != '0) begin
            crs_cnt_d = cnt_dec(crs_cnt_q);
            if (crs_cnt_q == DLY_W'(1)) begin
                crs_tx_d = 1'b0;
            end
        end else begin
            crs_tx_d = 1'b0;
        end
    end

    // Receive path, receive carrier and collision
    always_comb begin
        rxd_cnt_d = rxd_cnt_q;
        rxdv_d    = rxdv_q;
        rxd_d     = rxd_q;
        crs_rx_d  = crs_rx_q;
        col_cnt_d = col_cnt_q;
        col_d     = col_q;
        if (!done_q) begin
            rxdv_d    = 1'b0;
            crs_rx_d  = 1'b0;
            col_d     = 1'b0;
            rxd_cnt_d = '0;
        end else if (rx_on && !crs_rx_q) begin
            // receive start
            // At 100M the sync stages already use most of the budget
            rxd_cnt_d = SPEED_100 ? DLY_W'(RX100_CYC) : DLY_W'(RX10_CYC);
            crs_rx_d  = 1'b1;
        end else if (!rx_on && crs_rx_q && col_cnt_q == '0 && rxdv_q) begin
            // carrier and collision end after /T/
            col_cnt_d = DLY_W'(CRSE_CYC);
        end else if (col_cnt_q != '0) begin
            // One counter ends carrier, data valid and collision together
            col_cnt_d = cnt_dec(col_cnt_q);
            if (col_cnt_q == DLY_W'(1)) begin
                crs_rx_d = 1'b0;
                rxdv_d   = 1'b0;
                col_d    = 1'b0;
            end
        end
        if (rxd_cnt_q != '0) begin
            rxd_cnt_d = cnt_dec(rxd_cnt_q);
            if (rxd_cnt_q == DLY_W'(1)) begin
                rxdv_d = 1'b1;
            end
        end
        if (rx_on) begin
            rxd_d = rxn_q;
        end

        // collision while sending
        // Raised from the filtered line itself: waiting for receive carrier
        // would put it one cycle past the latest allowed time
        if (done_q && SPEED_100 && half && ten_f_q && rx_on && !col_q) begin
            col_d = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            txd_cnt_q <= '0;
            rxd_cnt_q <= '0;
            crs_cnt_q <= '0;
            col_cnt_q <= '0;
            ltx_q     <= 1'b0;
            ltn_q     <= 4'h0;
            rxdv_q    <= 1'b0;
            rxd_q     <= 4'h0;
            crs_tx_q  <= 1'b0;
            crs_rx_q  <= 1'b0;
            col_q     <= 1'b0;
        end else begin
            txd_cnt_q <= txd_cnt_d;
            rxd_cnt_q <= rxd_cnt_d;
            crs_cnt_q <= crs_cnt_d;
            col_cnt_q <= col_cnt_d;
            ltx_q     <= ltx_d;
            ltn_q     <= ltn_d;
            rxdv_q    <= rxdv_d;
            rxd_q     <= rxd_d;
            crs_tx_q  <= crs_tx_d;
            crs_rx_q  <= crs_rx_d;
            col_q     <= col_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // Carrier is the one output built from two flops; both are registered
    assign LINE_TRANSMIT_ACTIVE = ltx_q;
    assign LINE_TRANSMIT_NIBBLE = ltn_q;
    assign RXDV                 = rxdv_q;
    assign RXD                  = rxd_q;
    assign CRS                  = crs_tx_q | crs_rx_q;
    assign COL                  = col_q;
    assign RESET_DONE           = done_q;

endmodule : mpl_core
`default_nettype wire

// >>> rtl/mpl_pkg.sv
package mpl_pkg;
    // Reference clock
    localparam int unsigned CLK_PERIOD_NS    = 25;
    // Bit times (ns)
    localparam int unsigned BIT_NS_10M       = 100;
    localparam int unsigned BIT_NS_100M      = 10;
    // Latency and carrier limits, in tenths of a bit time
    localparam int unsigned RX10_MAX_DBT     = 70;
    localparam int unsigned TX10_MAX_DBT     = 20;
    localparam int unsigned TX100_MAX_DBT    = 30;
    localparam int unsigned CRS_TX100_DBT    = 30;
    localparam int unsigned CRS_OFF_DBT      = 30;
    localparam int unsigned CRS_TX10_DBT     = 20;
    localparam int unsigned RX100_MAX_DBT    = 170;
    localparam int unsigned CRS_RX_MIN_DBT   = 100;
    localparam int unsigned COL_RX_MIN_DBT   = 90;
    localparam int unsigned CRS_RXE_MIN_DBT  = 130;
    // Power-on reset
    localparam int unsigned POR_MIN_MS       = 40;
    localparam int unsigned POR_CYC          = POR_MIN_MS * 1000 * (1000 / CLK_PERIOD_NS);

    // Cycles of REF_CLK for a time in tenths of bits, rounded down, at least one
    function automatic int unsigned mpl_cyc(input int unsigned dbt, input int unsigned bit_ns);
        int unsigned c;
        c = (dbt * bit_ns) / (10 * CLK_PERIOD_NS);
        return (c < 1) ? 1 : c;
    endfunction : mpl_cyc

    // Cycles rounded up (least times)
    function automatic int unsigned mpl_cyc_up(input int unsigned dbt, input int unsigned bit_ns);
        return (dbt * bit_ns + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);
    endfunction : mpl_cyc_up

    // Receive budgets lose three sync stages, the filter flop and the load edge, five cycles in all
    localparam int unsigned RX10_CYC   = mpl_cyc(RX10_MAX_DBT, BIT_NS_10M) - 5;
    localparam int unsigned TX10_CYC   = mpl_cyc(TX10_MAX_DBT, BIT_NS_10M) - 4;
    localparam int unsigned CRS10_CYC  = mpl_cyc(CRS_TX10_DBT, BIT_NS_10M) - 4;
    localparam int unsigned OFF10_CYC  = mpl_cyc(CRS_OFF_DBT, BIT_NS_10M) - 4;
    localparam int unsigned RX100_CYC  = mpl_cyc(RX100_MAX_DBT, BIT_NS_100M) - 5;
    localparam int unsigned CRSR_CYC   = mpl_cyc_up(CRS_RX_MIN_DBT, BIT_NS_100M);
    localparam int unsigned COLR_CYC   = mpl_cyc_up(COL_RX_MIN_DBT, BIT_NS_100M);
    // End count sits after the sync stages and the load edge, so four come off
    localparam int unsigned CRSE_CYC   = mpl_cyc_up(CRS_RXE_MIN_DBT, BIT_NS_100M) - 4;
    localparam int DLY_W = 8;
endpackage : mpl_pkg

// >>> tb/mpl_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module mpl_mac_model (
    input  wire logic       tx_clk,
    input  wire logic       send,
    output logic            txen,
    output logic [3:0]      txd
);
    initial begin
        txen = 1'h0;
        txd  = 4'h0;
    end
    // one nibble per clock
    // Launch after the rising edge; idle data inverted so stale nibbles never pass
    always @(posedge tx_clk) begin
        txen <= send;
        txd  <= send ? txd + 4'h1 : ~txd;
    end
endmodule : mpl_mac_model
`default_nettype wire

// >>> tb/mpl_chk.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module mpl_chk #(
    parameter int unsigned POR_CYCLES = 20
) (
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       SPEED_100,
    input wire logic       FULL_DUPLEX,
    input wire logic       TXEN,
    input wire logic       LINE_RECEIVE_ACTIVE,
    input wire logic       LINE_RECEIVE_END,
    input wire logic       LINE_TRANSMIT_ACTIVE,
    input wire logic       RXDV,
    input wire logic       CRS,
    input wire logic       COL,
    input wire logic       RESET_DONE
);
    logic [31:0] up_q;
    logic [31:0] up_d;
    // Cycles since reset release; saturates so a long run cannot wrap
    always_comb up_d = up_q[31] ? up_q : up_q + 32'h1;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) up_q <= 32'h0;
        else up_q <= up_d;
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    // Start and end events seen at the ports
    sequence s_tx_on;
        RESET_DONE && !FULL_DUPLEX && $rose(TXEN);
    endsequence
    sequence s_tx_off;
        RESET_DONE && !FULL_DUPLEX && !LINE_RECEIVE_ACTIVE && $fell(TXEN);
    endsequence
    sequence s_rx_j;
        RESET_DONE && SPEED_100 && !TXEN && $rose(LINE_RECEIVE_ACTIVE);
    endsequence
    sequence s_rx_t;
        RESET_DONE && SPEED_100 && !TXEN && $rose(LINE_RECEIVE_END);
    endsequence
    sequence s_rx_10;
        RESET_DONE && !SPEED_100 && $rose(LINE_RECEIVE_ACTIVE);
    endsequence
    sequence s_rx_col;
        RESET_DONE && SPEED_100 && !FULL_DUPLEX && TXEN && $rose(LINE_RECEIVE_ACTIVE);
    endsequence
    sequence s_col_end;
        RESET_DONE && COL && $rose(LINE_RECEIVE_END);
    endsequence
    // Steady lead-in for the minimum, then the edge before the maximum
    sequence s_crs_up;
        !CRS [*3] ##[1:10] CRS;
    endsequence
    sequence s_crs_down;
        CRS [*5] ##[1:12] !CRS;
    endsequence
    a_crs_tx_rise: assert property (s_tx_on |-> ##[1:8] CRS)
        else $error("carrier late after transmit start");
    a_crs_tx_fall: assert property (s_tx_off |-> ##[1:16] !CRS)
        else $error("carrier late to drop after transmit");
    a_line_start: assert property (s_tx_on |-> ##[1:17] LINE_TRANSMIT_ACTIVE)
        else $error("line output late");
    a_rx_fast: assert property (s_rx_j |-> ##[1:10] RXDV)
        else $error("receive data late at 100M");
    a_rx_slow: assert property (s_rx_10 |-> ##[1:28] RXDV)
        else $error("receive data late at 10M");
    a_crs_rx_rise: assert property (s_rx_j |-> s_crs_up)
        else $error("receive carrier outside window");
    a_crs_rx_fall: assert property (s_rx_t |-> s_crs_down)
        else $error("receive carrier drop outside window");
    a_col_rise: assert property (s_rx_col |-> !COL [*3] ##[1:10] COL)
        else $error("collision outside window");
    a_col_fall: assert property (s_col_end |-> COL [*5] ##[1:12] !COL)
        else $error("collision drop outside window");
    a_por_min: assert property (RESET_DONE |-> up_q >= POR_CYCLES - 1)
        else $error("power-up finished early");
endmodule : mpl_chk
bind mpl_core mpl_chk #(.POR_CYCLES(POR_CYCLES)) chk_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
    .TXEN(TXEN), .LINE_RECEIVE_ACTIVE(LINE_RECEIVE_ACTIVE), .LINE_RECEIVE_END(LINE_RECEIVE_END),
    .LINE_TRANSMIT_ACTIVE(LINE_TRANSMIT_ACTIVE), .RXDV(RXDV), .CRS(CRS), .COL(COL),
    .RESET_DONE(RESET_DONE)
);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tb;
    logic       ref_clk = 1'h0;
    logic       rst_n = 1'h0;
    logic       tx_clk = 1'h0;
    logic       spd = 1'h0;
    logic       fdx = 1'h0;
    logic       send = 1'h0;
    logic       lra = 1'h0;
    logic [3:0] lrn = 4'h0;
    logic       lre = 1'h0;
    logic       txen;
    logic [3:0] txd;
    logic       line_act, rxdv, crs, col, done;
    logic [3:0] rxd;
    logic [3:0] ltn;
    int         num_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;
    // Clocks; link clock offset so its edges never meet the core edges
    always #12.5 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #100 tx_clk = ~tx_clk;
    end
    mpl_core #(.POR_CYCLES(20)) dut_u (
        .REF_CLK(ref_clk), .RST_N(rst_n), .SPEED_100(spd), .FULL_DUPLEX(fdx),
        .TX_CLK_IN(tx_clk), .TXEN(txen), .TXD(txd), .LINE_RECEIVE_ACTIVE(lra),
        .LINE_RECEIVE_NIBBLE(lrn), .LINE_RECEIVE_END(lre), .LINE_TRANSMIT_ACTIVE(line_act),
        .LINE_TRANSMIT_NIBBLE(ltn), .RXDV(rxdv), .RXD(rxd), .CRS(crs), .COL(col),
        .RESET_DONE(done)
    );
    mpl_mac_model mac_u (.tx_clk(tx_clk), .send(send), .txen(txen), .txd(txd));
    ////////////////////////////////////////////////////////////
    // Verdict in one place
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    function automatic logic pick(input int w);
        case (w)
            0: return crs;
            1: return line_act;
            2: return rxdv;
            3: return col;
            default: return done;
        endcase
    endfunction : pick
    // Bounded wait for a level, sampled on falling edges where outputs are settled
    task automatic wait_lvl(input int w, input logic lvl, input int lim, input string nm);
        int n;
        n = 0;
        while (pick(w) !== lvl && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        total_checks++;
        if (pick(w) !== lvl) begin
            $display("Error %s expected %0b seen %0b", nm, lvl, pick(w));
            num_errors++;
        end
    endtask : wait_lvl
    // Nibble compare against a value known from the stimulus
    task automatic check4(input string nm, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %0h seen %0h", nm, exp, got);
            num_errors++;
        end
    endtask : check4
    // Reset, early traffic refused, then power-up completes
    task automatic t_por();
        repeat (10) @(negedge ref_clk);
        rst_n = 1'h1;
        lra = 1'h1;
        wait_lvl(0, 1'h0, 0, "early_carrier");
        repeat (5) @(negedge ref_clk);
        wait_lvl(0, 1'h0, 0, "early_carrier");
        lra = 1'h0;
        wait_lvl(4, 1'h1, 20, "reset_done");
    endtask : t_por
    // Half-duplex frame out: carrier and line start, then carrier drop
    task automatic t_tx(input logic s);
        logic [3:0] first;
        spd = s;
        send = 1'h1;
        @(posedge txen);
        @(negedge ref_clk);
        first = txd;
        fork
            wait_lvl(0, 1'h1, 8, "tx_carrier");
            wait_lvl(1, 1'h1, 17, "line_active");
        join
        check4("tx_nibble", first, ltn);
        repeat (20) @(negedge ref_clk);
        send = 1'h0;
        @(negedge txen);
        @(negedge ref_clk);
        wait_lvl(0, 1'h0, 16, "tx_carrier_off");
        wait_lvl(1, 1'h0, 30, "line_idle");
    endtask : t_tx
    // Frame in from the line
    task automatic t_rx(input logic s);
        spd = s;
        lrn = 4'h5;
        lra = 1'h1;
        fork
            wait_lvl(2, 1'h1, s ? 10 : 28, "rx_valid");
            if (s) wait_lvl(0, 1'h1, 10, "rx_carrier");
        join
        check4("rx_data", 4'h5, rxd);
        repeat (8) @(negedge ref_clk) lrn = lrn + 4'h1;
        lre = 1'h1;
        fork
            if (s) wait_lvl(0, 1'h0, 12, "rx_carrier_off");
            wait_lvl(2, 1'h0, 12, "rx_valid_off");
        join
        lra = 1'h0;
        @(negedge ref_clk);
        lre = 1'h0;
        repeat (4) @(negedge ref_clk);
    endtask : t_rx
    // Full duplex: line output runs, transmit carrier stays off
    task automatic t_fdx();
        fdx = 1'h1;
        spd = 1'h1;
        send = 1'h1;
        @(posedge txen);
        @(negedge ref_clk);
        wait_lvl(1, 1'h1, 17, "fdx_line_active");
        wait_lvl(0, 1'h0, 0, "fdx_no_carrier");
        send = 1'h0;
        @(negedge txen);
        @(negedge ref_clk);
        wait_lvl(1, 1'h0, 30, "fdx_line_idle");
        fdx = 1'h0;
    endtask : t_fdx
    // Line frame arrives while sending at 100M half duplex
    task automatic t_col();
        spd = 1'h1;
        send = 1'h1;
        @(posedge txen);
        repeat (8) @(negedge ref_clk);
        lra = 1'h1;
        wait_lvl(3, 1'h1, 10, "collision_on");
        repeat (6) @(negedge ref_clk);
        lre = 1'h1;
        wait_lvl(3, 1'h0, 12, "collision_off");
        lra = 1'h0;
        @(negedge ref_clk);
        lre = 1'h0;
        send = 1'h0;
        wait_lvl(0, 1'h0, 30, "carrier_idle");
    endtask : t_col
    initial begin
        t_por();
        t_tx(1'h1);
        t_tx(1'h0);
        t_fdx();
        t_rx(1'h1);
        t_rx(1'h0);
        t_col();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
